/* File: pkg/sound_pkg.sv */
// register map, field layout and shared types of the sound unit
package sound_pkg;
  // register index on the plain register port
  localparam logic [2:0] ADDR_CLOCK_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_MODE_SELECT  = 3'h1;
  localparam logic [2:0] ADDR_CONTROL      = 3'h2;
  localparam logic [2:0] ADDR_BUFFER       = 3'h3;
  localparam logic [2:0] ADDR_FLAGS        = 3'h4;
  localparam logic [2:0] ADDR_IRQ_ENABLE   = 3'h5;
  // field positions
  localparam int DEBUG_RUN_BIT = 8;
  localparam int DIV_LSB       = 4;
  localparam int SRC_LSB       = 0;
  localparam int TEMPO_LSB     = 8;
  localparam int DRIVE_BIT     = 2;
  localparam int MODE_LSB      = 0;
  localparam int STOP_BIT      = 8;
  localparam int ENABLE_BIT    = 0;
  localparam int BUSY_BIT      = 8;
  localparam int EMPTY_BIT     = 1;
  localparam int DONE_BIT      = 0;
  // reset values
  localparam logic [15:0] BUFFER_RESET = 16'h00ff;
  localparam logic [2:0]  DIV_RESET    = 3'h0;
  localparam logic [3:0]  TEMPO_RESET  = 4'h0;
  localparam logic [1:0]  IE_RESET     = 2'h0;
  // divider codes
  localparam logic [2:0] DIV_BYPASS   = 3'h7;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam logic [7:0] DIV_BASE     = 8'h04;
  localparam logic [7:0] DIV_ONE      = 8'h01;
  // sound clock ticks of one tempo unit at tempo code zero
  localparam int UNIT_TICKS = 512;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_LOW      = 2'h1,
    SRC_HIGH     = 2'h2,
    SRC_EXTERNAL = 2'h3
  } clk_src_e;

  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'h0,
    MODE_ONESHOT = 2'h1,
    MODE_MELODY  = 2'h2,
    MODE_RSVD    = 2'h3
  } out_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PLAY = 2'b01,
    ST_STOP = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic       tie_slur;
    logic       note_rest_sel;
    logic [5:0] length_duty_sel;
    logic [7:0] pitch_freq_sel;
  } note_s;
endpackage

/* File: logic/sound_clock_gen.sv */
// source select and divider for the sound clock enable
`timescale 1ns/1ps
module sound_clock_gen
  import sound_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // source ticks indexed by source code
  input  wire logic [3:0] osc_tick,
  // settings
  input  wire clk_src_e   src,
  input  wire logic [2:0] div,
  input  wire logic       run,
  // divided enable
  output logic            sound_tick
);
  if (CNT_W < 8) begin : g_chk
    $error("sound_clock_gen: CNT_W below 8");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] ratio;
  logic             valid;

  // ratio from source and divider code
  always_comb begin
    valid = 1'b0;
    ratio = CNT_W'(DIV_ONE);
    if ((src == SRC_INTERNAL || src == SRC_HIGH) && div <= DIV_MAX_CODE) begin
      valid = 1'b1;
      ratio = CNT_W'(DIV_BASE) << div;
    end else if ((src == SRC_LOW || src == SRC_EXTERNAL) &&
                 div == DIV_BYPASS) begin
      valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    sound_tick <= 1'b0;
    if (rst) begin
      cnt_r <= '0;
    end else if (run && valid && osc_tick[src]) begin
      if (cnt_r >= ratio - CNT_W'(1)) begin
        cnt_r      <= '0;
        sound_tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end
endmodule // sound_clock_gen

/* File: logic/sound_tone_gen.sv */
// square wave for buzzer and melody tones
`timescale 1ns/1ps
module sound_tone_gen
  import sound_pkg::*;
(
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst,
  // control
  input  wire logic  tick,
  input  wire logic  restart,
  input  wire logic  melody,
  input  wire note_s note,
  // wave
  output logic       wave
);
  logic [7:0]  phase_r;
  logic [8:0]  period;
  logic [15:0] duty_lim;
  logic [15:0] phase_sc;

  always_comb begin
    if (melody) begin
      period = {1'b0, note.pitch_freq_sel} + 9'h001;
    end else begin
      period = {3'h0, note.pitch_freq_sel[5:0]} + 9'h001;
    end
    duty_lim = 16'(period) * 16'({1'b0, note.length_duty_sel} + 7'h01);
    phase_sc = {2'h0, phase_r, 6'h00};
    if (melody) begin
      wave = ({1'b0, phase_r} < (period >> 1));
    end else begin
      wave = (phase_sc < duty_lim);
    end
  end

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      phase_r <= '0;
    end else if (tick) begin
      if ({1'b0, phase_r} >= period - 9'h001) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + 8'h01;
      end
    end
  end
endmodule // sound_tone_gen

/* File: logic/sound_unit.sv */
// sound unit: registers, note sequencer and output pin pair
//
// Operation
// - debug-run keeps sound clock during debug
// - clock source code picks one oscillator
// - divider code sets source division ratio
// - tempo code sets tempo or one-shot time
// - drive mode bit picks normal or direct
// - mode code picks buzzer, one-shot, melody
// - stop write sets bit, clears at completion
// - stop ends one-shot or melody early
// - unit enable gates operating clock
// - buffer write starts sound output
// - tie continues previous note in melody
// - rest drives pin low, inverted high
// - length sets note time or duty
// - pitch sets scale or buzzer frequency
// - only full-width buffer writes accepted
// - empty flag resets set, buffer write clears
// - done flag cleared by one or write
// - busy status bit reads, resets zero
// - busy high while sound output runs
// - empty set on load or stop
// - interrupt only when flag and enable
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module sound_unit
  import sound_pkg::*;
#(
  parameter int DUR_W = 21
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_wr_full,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // clock source ticks and debug state
  input  wire logic        internal_osc,
  input  wire logic        low_speed_osc,
  input  wire logic        high_speed_osc,
  input  wire logic        external_clock_in,
  input  wire logic        debug_mode,
  // pins and interrupt request
  output logic             buzzer_out,
  output logic             buzzer_out_inv,
  output logic             sound_irq
);
  if (DUR_W < 21) begin : g_chk
    $error("sound_unit: DUR_W below 21");
  end

  logic             debug_run_r;
  logic [2:0]       clock_divider_sel_r;
  clk_src_e         clock_source_sel_r;
  logic [3:0]       tempo_duration_sel_r;
  logic             pin_drive_mode_r;
  out_mode_e        output_mode_sel_r;
  logic             stop_request_r;
  logic             unit_enable_r;
  note_s            buf_r;
  note_s            cur_r;
  logic             pending_r;
  seq_state_e       state_r;
  logic             buffer_empty_flag_r;
  logic             output_done_flag_r;
  logic [1:0]       irq_enable_r;
  logic [DUR_W-1:0] dur_r;

  logic             run;
  logic             sound_tick;
  logic             wave;
  logic             wr_buf;
  logic             wr_stop;
  logic             wr_done_clr;
  logic             melody;
  logic             dur_end;
  logic             load;
  logic             finish;
  logic             restart;
  logic [13:0]      unit_w;
  logic [DUR_W-1:0] target;
  note_s            wr_note;

  assign wr_note     = note_s'(reg_wdata);
  assign wr_buf      = reg_wr && reg_addr == ADDR_BUFFER && reg_wr_full;
  assign wr_stop     = reg_wr && reg_addr == ADDR_CONTROL &&
                       reg_wdata[STOP_BIT];
  assign wr_done_clr = reg_wr && reg_addr == ADDR_FLAGS &&
                       reg_wdata[DONE_BIT];
  assign melody      = output_mode_sel_r == MODE_MELODY;
  assign dur_end     = dur_r == '0;

  // clock gating by enable and debug state
  assign run = unit_enable_r && (!debug_mode || debug_run_r);

  sound_clock_gen #(
    .CNT_W (8)
  ) u_clk (
    .clock      (clock),
    .rst        (rst),
    .osc_tick   ({external_clock_in, high_speed_osc,
                  low_speed_osc, internal_osc}),
    .src        (clock_source_sel_r),
    .div        (clock_divider_sel_r),
    .run        (run),
    .sound_tick (sound_tick)
  );

  // duration of the next note in sound ticks
  always_comb begin
    unit_w = 14'(({1'b0, tempo_duration_sel_r} + 5'h01) * UNIT_TICKS);
    if (output_mode_sel_r == MODE_ONESHOT) begin
      target = DUR_W'(unit_w);
    end else begin
      target = DUR_W'(unit_w) *
               DUR_W'({1'b0, buf_r.length_duty_sel} + 7'h01);
    end
  end

  // sequencer events
  always_comb begin
    load   = 1'b0;
    finish = 1'b0;
    if (sound_tick && pending_r && output_mode_sel_r != MODE_RSVD) begin
      case (state_r)
        ST_IDLE: load = 1'b1;
        ST_PLAY: load = output_mode_sel_r == MODE_NORMAL ||
                        (melody && dur_end);
        default: load = 1'b0;
      endcase
    end
    if (sound_tick) begin
      case (state_r)
        ST_PLAY: finish = !load && dur_end &&
                          output_mode_sel_r != MODE_NORMAL;
        ST_STOP: finish = 1'b1;
        default: finish = 1'b0;
      endcase
    end
  end

  assign restart = load && !(melody && buf_r.tie_slur);

  sound_tone_gen u_tone (
    .clock   (clock),
    .rst     (rst),
    .tick    (sound_tick),
    .restart (restart),
    .melody  (melody),
    .note    (cur_r),
    .wave    (wave)
  );

  // clock configuration register
  always_ff @(posedge clock) begin
    if (rst) begin
      debug_run_r         <= 1'b0;
      clock_divider_sel_r <= DIV_RESET;
      clock_source_sel_r  <= SRC_INTERNAL;
    end else if (reg_wr && reg_addr == ADDR_CLOCK_CONFIG) begin
      debug_run_r         <= reg_wdata[DEBUG_RUN_BIT];
      clock_divider_sel_r <= reg_wdata[DIV_LSB +: 3];
      clock_source_sel_r  <= clk_src_e'(reg_wdata[SRC_LSB +: 2]);
    end
  end

  // mode select register
  always_ff @(posedge clock) begin
    if (rst) begin
      tempo_duration_sel_r <= TEMPO_RESET;
      pin_drive_mode_r     <= 1'b0;
      output_mode_sel_r    <= MODE_NORMAL;
    end else if (reg_wr && reg_addr == ADDR_MODE_SELECT) begin
      tempo_duration_sel_r <= reg_wdata[TEMPO_LSB +: 4];
      pin_drive_mode_r     <= reg_wdata[DRIVE_BIT];
      output_mode_sel_r    <= out_mode_e'(reg_wdata[MODE_LSB +: 2]);
    end
  end

  // enable and interrupt enable
  always_ff @(posedge clock) begin
    if (rst) begin
      unit_enable_r <= 1'b0;
      irq_enable_r  <= IE_RESET;
    end else begin
      if (reg_wr && reg_addr == ADDR_CONTROL) begin
        unit_enable_r <= reg_wdata[ENABLE_BIT];
      end
      if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) begin
        irq_enable_r <= reg_wdata[EMPTY_BIT:DONE_BIT];
      end
    end
  end

  // stop request: write one sets, completion clears
  always_ff @(posedge clock) begin
    if (rst) begin
      stop_request_r <= 1'b0;
    end else if (wr_stop) begin
      stop_request_r <= 1'b1;
    end else if (sound_tick && state_r != ST_PLAY) begin
      stop_request_r <= 1'b0;
    end
  end

  // sound buffer and pending marker
  always_ff @(posedge clock) begin
    if (rst) begin
      buf_r     <= note_s'(BUFFER_RESET);
      pending_r <= 1'b0;
    end else if (wr_buf) begin
      buf_r     <= wr_note;
      pending_r <= 1'b1;
    end else if (load || wr_stop) begin
      pending_r <= 1'b0;
    end
  end

  // sequencer state, working note and duration
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cur_r   <= note_s'(BUFFER_RESET);
      dur_r   <= '0;
    end else begin
      if (load) begin
        cur_r <= buf_r;
        dur_r <= target - DUR_W'(1);
      end else if (sound_tick && !dur_end) begin
        dur_r <= dur_r - DUR_W'(1);
      end
      case (state_r)
        ST_IDLE: begin
          if (load) begin
            state_r <= ST_PLAY;
          end
        end
        ST_PLAY: begin
          if (stop_request_r) begin
            state_r <= ST_STOP;
          end else if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        ST_STOP: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // buffer empty flag, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      buffer_empty_flag_r <= 1'b1;
    end else if (load || wr_stop) begin
      buffer_empty_flag_r <= 1'b1;
    end else if (wr_buf) begin
      buffer_empty_flag_r <= 1'b0;
    end
  end

  // output done flag, set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      output_done_flag_r <= 1'b0;
    end else if (finish && state_r != ST_IDLE) begin
      output_done_flag_r <= 1'b1;
    end else if (wr_buf || wr_done_clr) begin
      output_done_flag_r <= 1'b0;
    end
  end

  // pin pair
  always_ff @(posedge clock) begin
    if (rst || state_r == ST_IDLE) begin
      buzzer_out     <= 1'b0;
      buzzer_out_inv <= 1'b0;
    end else if (melody && cur_r.note_rest_sel) begin
      buzzer_out     <= 1'b0;
      buzzer_out_inv <= 1'b1;
    end else begin
      buzzer_out     <= wave;
      buzzer_out_inv <= pin_drive_mode_r && !wave;
    end
  end

  // interrupt request
  always_ff @(posedge clock) begin
    if (rst) begin
      sound_irq <= 1'b0;
    end else begin
      sound_irq <= |({buffer_empty_flag_r, output_done_flag_r} &
                     irq_enable_r);
    end
  end

  // read data, one cycle after the strobe only
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_addr == ADDR_CLOCK_CONFIG) begin
        reg_rdata[DEBUG_RUN_BIT]  <= debug_run_r;
        reg_rdata[DIV_LSB +: 3]   <= clock_divider_sel_r;
        reg_rdata[SRC_LSB +: 2]   <= clock_source_sel_r;
      end else if (reg_addr == ADDR_MODE_SELECT) begin
        reg_rdata[TEMPO_LSB +: 4] <= tempo_duration_sel_r;
        reg_rdata[DRIVE_BIT]      <= pin_drive_mode_r;
        reg_rdata[MODE_LSB +: 2]  <= output_mode_sel_r;
      end else if (reg_addr == ADDR_CONTROL) begin
        reg_rdata[STOP_BIT]       <= stop_request_r;
        reg_rdata[ENABLE_BIT]     <= unit_enable_r;
      end else if (reg_addr == ADDR_BUFFER) begin
        reg_rdata                 <= buf_r;
      end else if (reg_addr == ADDR_FLAGS) begin
        reg_rdata[BUSY_BIT]       <= state_r != ST_IDLE;
        reg_rdata[EMPTY_BIT]      <= buffer_empty_flag_r;
        reg_rdata[DONE_BIT]       <= output_done_flag_r;
      end else if (reg_addr == ADDR_IRQ_ENABLE) begin
        reg_rdata[EMPTY_BIT:DONE_BIT] <= irq_enable_r;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_stop_write;
    reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[STOP_BIT];
  endsequence

  sequence s_stop_end;
    state_r == ST_STOP && sound_tick;
  endsequence

  sequence s_no_enable_2;
    irq_enable_r == 2'h0 ##1 irq_enable_r == 2'h0;
  endsequence

  AST_DEBUG_HOLD: assert property (
    debug_mode && !debug_run_r |-> ##1 !sound_tick)
    else $error("sound tick during debug without debug run");

  AST_DISABLED_HOLD: assert property (
    !unit_enable_r ##1 !unit_enable_r |-> !sound_tick)
    else $error("sound tick while unit disabled");

  AST_DIV_BYPASS: assert property (
    clock_source_sel_r == SRC_LOW && clock_divider_sel_r != DIV_BYPASS
    ##1 $stable(clock_divider_sel_r) |-> !sound_tick)
    else $error("low speed source ticked without bypass code");

  AST_STOP_SET: assert property (
    s_stop_write |=> stop_request_r && buffer_empty_flag_r)
    else $error("stop write did not set stop and empty");

  AST_STOP_END: assert property (
    s_stop_end |=> state_r == ST_IDLE && output_done_flag_r
                   ##1 !buzzer_out && !buzzer_out_inv)
    else $error("stop did not end output with done flag");

  AST_BUF_NARROW: assert property (
    reg_wr && reg_addr == ADDR_BUFFER && !reg_wr_full |=> $stable(buf_r))
    else $error("narrow write changed sound buffer");

  AST_EMPTY_CLEAR: assert property (
    wr_buf && !load && !wr_stop |=> !buffer_empty_flag_r)
    else $error("buffer write did not clear empty flag");

  AST_LOAD_EMPTY: assert property (
    load |=> buffer_empty_flag_r && state_r != ST_IDLE && cur_r == $past(buf_r))
    else $error("load did not set empty and start output");

  AST_DONE_CLEAR: assert property (
    wr_done_clr && !finish |=> !output_done_flag_r)
    else $error("done flag not cleared by write one");

  AST_REST_PINS: assert property (
    state_r == ST_PLAY && melody && cur_r.note_rest_sel
    |=> !buzzer_out && buzzer_out_inv)
    else $error("rest did not hold pin pair");

  AST_BUSY_READ: assert property (
    reg_rd && reg_addr == ADDR_FLAGS
    |=> reg_rdata[BUSY_BIT] == ($past(state_r) != ST_IDLE))
    else $error("busy bit does not follow sequencer");

  AST_IRQ_MASK: assert property (
    s_no_enable_2 |-> !sound_irq)
    else $error("interrupt raised with all enables off");

  AST_RSVD_ZERO: assert property (
    reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata[15:9] == 7'h00)
    else $error("reserved control bits read nonzero");
endmodule // sound_unit

/* File: dv/buzzer_model.sv */
// external buzzer model that watches the pin pair
`timescale 1ns/1ps
module buzzer_model (
  // clock
  input  wire logic        clock,
  // pins
  input  wire logic        buzzer_out,
  input  wire logic        buzzer_out_inv,
  // observed activity
  output logic      [15:0] edge_count,
  output logic             rest_seen
);
  logic last_r;
  initial begin
    edge_count = 16'h0000;
    rest_seen = 1'b0;
    last_r = 1'b0;
  end
  // counts tone transitions, notes a rest pattern on the pair
  always @(posedge clock) begin
    if (buzzer_out !== last_r) edge_count <= edge_count + 16'h0001;
    last_r <= buzzer_out;
    if (buzzer_out === 1'b0 && buzzer_out_inv === 1'b1) rest_seen <= 1'b1;
  end
endmodule // buzzer_model

/* File: dv/tb_sound_unit.sv */
// self-checking bench for the sound unit
`timescale 1ns/1ps
module tb_sound_unit
  import sound_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_wr_full = 1'b1;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        osc = 1'b0;
  logic        debug_mode = 1'b0;
  logic        buzzer_out;
  logic        buzzer_out_inv;
  logic        sound_irq;
  logic [15:0] edge_count;
  logic        rest_seen;
  logic [15:0] e0;
  int          n;
  int          bad_count = 0;
  int          total_checks = 0;

  always #10 clock = ~clock;
  // one source pulse every other cycle
  always @(posedge clock) osc <= ~osc;

  sound_unit uut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_wr_full(reg_wr_full), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .internal_osc(osc), .low_speed_osc(osc),
    .high_speed_osc(osc), .external_clock_in(osc), .debug_mode(debug_mode),
    .buzzer_out(buzzer_out), .buzzer_out_inv(buzzer_out_inv),
    .sound_irq(sound_irq));
  buzzer_model buzzer (
    .clock(clock), .buzzer_out(buzzer_out),
    .buzzer_out_inv(buzzer_out_inv), .edge_count(edge_count),
    .rest_seen(rest_seen));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d,
                    input logic f);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_full <= f;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic expect_reg(input string nm, input logic [2:0] a,
                            input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  // polls a register field until it matches, bounded
  task automatic wait_reg(input logic [2:0] a, input logic [15:0] m,
                          input logic [15:0] v, input int lim,
                          output int cnt);
    logic [15:0] d;
    cnt = 0;
    rd(a, d);
    while ((d & m) !== v) begin
      cnt++;
      if (cnt > lim) begin
        bad_count++;
        $display("CHECK FAILED wait expected %h seen %h", v, d & m);
        give_verdict();
      end
      rd(a, d);
    end
  endtask

  task automatic t_reset_and_reserved();
    expect_reg("flags", ADDR_FLAGS, 16'h0002);
    expect_reg("buffer", ADDR_BUFFER, 16'h00ff);
    expect_reg("unmapped", 3'h7, 16'h0000);
    wr(ADDR_CLOCK_CONFIG, 16'hffff, 1'b1);
    expect_reg("clock config", ADDR_CLOCK_CONFIG, 16'h0173);
    wr(ADDR_MODE_SELECT, 16'hffff, 1'b1);
    expect_reg("mode select", ADDR_MODE_SELECT, 16'h0f07);
    wr(ADDR_IRQ_ENABLE, 16'hffff, 1'b1);
    expect_reg("irq enable", ADDR_IRQ_ENABLE, 16'h0003);
    chk("irq empty", 16'h0001, {15'h0000, sound_irq});
    wr(ADDR_IRQ_ENABLE, 16'h0000, 1'b1);
    wr(ADDR_BUFFER, 16'h1234, 1'b0);
    expect_reg("narrow write", ADDR_BUFFER, 16'h00ff);
    chk("irq masked", 16'h0000, {15'h0000, sound_irq});
    $display("test reset and reserved done");
  endtask

  task automatic t_oneshot();
    wr(ADDR_CLOCK_CONFIG, 16'h0071, 1'b1);
    wr(ADDR_MODE_SELECT, 16'h0001, 1'b1);
    debug_mode <= 1'b1;
    wr(ADDR_CONTROL, 16'h0001, 1'b1);
    e0 = edge_count;
    wr(ADDR_BUFFER, 16'h0303, 1'b1);
    repeat (40) @(posedge clock);
    expect_reg("debug hold", ADDR_FLAGS, 16'h0000);
    debug_mode <= 1'b0;
    wait_reg(ADDR_FLAGS, 16'h0100, 16'h0100, 20, n);
    expect_reg("busy", ADDR_FLAGS, 16'h0102);
    wait_reg(ADDR_FLAGS, 16'h0100, 16'h0000, 600, n);
    chk("oneshot length", 16'h0001, {15'h0000, n >= 500 && n <= 516});
    expect_reg("done", ADDR_FLAGS, 16'h0003);
    chk("tone", 16'h0001, {15'h0000, edge_count != e0});
    chk("direct drive", 16'h0000, {15'h0000, rest_seen});
    wr(ADDR_IRQ_ENABLE, 16'h0001, 1'b1);
    repeat (3) @(posedge clock);
    chk("irq done", 16'h0001, {15'h0000, sound_irq});
    $display("test oneshot done");
  endtask

  task automatic t_melody_rest();
    wr(ADDR_CONTROL, 16'h0000, 1'b1);
    wr(ADDR_MODE_SELECT, 16'h0002, 1'b1);
    e0 = edge_count;
    wr(ADDR_BUFFER, 16'h4010, 1'b1);
    expect_reg("written", ADDR_FLAGS, 16'h0000);
    chk("irq cleared", 16'h0000, {15'h0000, sound_irq});
    wr(ADDR_CONTROL, 16'h0001, 1'b1);
    wait_reg(ADDR_FLAGS, 16'h0100, 16'h0100, 20, n);
    repeat (4) @(posedge clock);
    chk("rest", 16'h0001, {14'h0000, buzzer_out, buzzer_out_inv});
    wait_reg(ADDR_FLAGS, 16'h0100, 16'h0000, 600, n);
    chk("melody length", 16'h0001, {15'h0000, n >= 500 && n <= 516});
    chk("rest silent", e0, edge_count);
    wr(ADDR_FLAGS, 16'h0003, 1'b1);
    expect_reg("w1c", ADDR_FLAGS, 16'h0002);
    $display("test melody rest done");
  endtask

  task automatic t_stop();
    wr(ADDR_MODE_SELECT, 16'h0004, 1'b1);
    e0 = edge_count;
    wr(ADDR_BUFFER, 16'h0004, 1'b1);
    wait_reg(ADDR_FLAGS, 16'h0100, 16'h0100, 20, n);
    repeat (60) @(posedge clock);
    chk("normal tone", 16'h0001, {15'h0000, edge_count != e0});
    chk("drive", 16'h0001, {15'h0000, buzzer_out ^ buzzer_out_inv});
    wr(ADDR_CONTROL, 16'h0101, 1'b1);
    wait_reg(ADDR_CONTROL, 16'h0100, 16'h0000, 10, n);
    expect_reg("stopped", ADDR_FLAGS, 16'h0003);
    chk("idle", 16'h0000, {14'h0000, buzzer_out, buzzer_out_inv});
    wr(ADDR_CONTROL, 16'h0000, 1'b1);
    wr(ADDR_BUFFER, 16'h0004, 1'b1);
    repeat (40) @(posedge clock);
    expect_reg("disabled", ADDR_FLAGS, 16'h0000);
    wr(ADDR_CLOCK_CONFIG, 16'h0001, 1'b1);
    wr(ADDR_CONTROL, 16'h0001, 1'b1);
    repeat (40) @(posedge clock);
    expect_reg("reserved divider", ADDR_FLAGS, 16'h0000);
    wr(ADDR_CONTROL, 16'h0000, 1'b1);
    wr(ADDR_CLOCK_CONFIG, 16'h0071, 1'b1);
    wr(ADDR_CONTROL, 16'h0100, 1'b1);
    expect_reg("stop bit", ADDR_CONTROL, 16'h0100);
    expect_reg("stop empty", ADDR_FLAGS, 16'h0002);
    wr(ADDR_CONTROL, 16'h0001, 1'b1);
    wait_reg(ADDR_CONTROL, 16'h0100, 16'h0000, 10, n);
    repeat (20) @(posedge clock);
    expect_reg("dropped", ADDR_FLAGS, 16'h0002);
    $display("test stop done");
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset_and_reserved();
    t_oneshot();
    t_melody_rest();
    t_stop();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("CHECK FAILED run length expected finish seen timeout");
    give_verdict();
  end
endmodule // tb_sound_unit
